// ==== rtl/smt_pin_filter.sv ====
`timescale 1ns/1ns
module smt_pin_filter
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Pin and filtered result
  input  wire logic timer_input_pin,
  smt_pin_if.drv    filt
);
  import smt_pkg::*;

  typedef struct packed {
    logic [2:0]        sync;
    logic              level;
    logic [FILT_W-1:0] cnt;
    logic              rise;
    logic              fall;
  } smt_filt_s;

  smt_filt_s s;
  smt_filt_s next_s;

  // A new level must stay put for the accept count, so short glitches never reach the timer.
  always_comb
  begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], timer_input_pin};
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (s.sync[2] == s.sync[1] && s.sync[2] != s.level)
    begin
      if (s.cnt == FILT_ACCEPT_CYC - FILT_ONE)
      begin
        next_s.level = s.sync[2];
        next_s.rise  = s.sync[2];
        next_s.fall  = ~s.sync[2];
        next_s.cnt   = FILT_CLEAR;
      end
      else
      begin
        next_s.cnt = s.cnt + FILT_ONE;
      end
    end
    else
    begin
      next_s.cnt = FILT_CLEAR;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else if (clk_en)
      s <= next_s;
  end

  assign filt.level = s.level;
  assign filt.rise  = s.rise;
  assign filt.fall  = s.fall;

  hold_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && s.cnt != FILT_ACCEPT_CYC - FILT_ONE |=> $stable(s.level))
    else $error("Filtered level changed before the accept count.");

  reject_glitch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && s.sync[2] != s.sync[1] |=> s.cnt == FILT_CLEAR && $stable(s.level))
    else $error("Unsettled pin sample did not restart the filter.");

endmodule // smt_pin_filter

// ==== rtl/smt_pin_if.sv ====
`timescale 1ns/1ns
interface smt_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport drv (output level, output rise, output fall);
  modport rcv (input level, input rise, input fall);
endinterface

// ==== rtl/smt_pkg.sv ====
package smt_pkg;

  // Register port, counter, prescaler and filter widths.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned DIV_W  = 13;
  localparam int unsigned FILT_W = 4;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_PERIOD_LO  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD_HI  = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_LO = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_HI = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'h14;

  // Reset and fixed values.
  localparam logic [DATA_W-1:0] CTL_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE    = 8'h00;
  localparam logic [CNT_W-1:0]  PERIOD_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0]  CAPTURE_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_CLEAR     = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 16'h0001;
  localparam logic [DIV_W-1:0]  DIV_CLEAR     = 13'h0000;
  localparam logic [DIV_W-1:0]  DIV_ONE       = 13'h0001;
  localparam logic [FILT_W-1:0] FILT_CLEAR    = 4'h0;
  localparam logic [FILT_W-1:0] FILT_ONE      = 4'h1;

  // Prescaler exponents of the three internal source clocks.
  localparam logic [3:0] DIV_EXP_SLOW = 4'hb;
  localparam logic [3:0] DIV_EXP_MID  = 4'h7;
  localparam logic [3:0] DIV_EXP_FAST = 4'h3;

  // Input noise filter timing, in periods of fc, which is the core clock.
  localparam int unsigned CORE_CLK_HZ     = 20_000_000;
  localparam int unsigned FC_HZ           = CORE_CLK_HZ;
  localparam int unsigned NOISE_REJECT_FC = 7;
  localparam int unsigned EDGE_MIN_FC     = 13;
  localparam logic [FILT_W-1:0] FILT_ACCEPT_CYC = FILT_W'(NOISE_REJECT_FC * (CORE_CLK_HZ / FC_HZ) + 1);

  typedef enum logic [1:0] {
    MODE_TIMER  = 2'b00,
    MODE_WINDOW = 2'b01,
    MODE_PULSE  = 2'b10,
    MODE_PPG    = 2'b11
  } smt_mode_e;

  typedef enum logic [1:0] {
    CLK_SLOW = 2'b00,
    CLK_MID  = 2'b01,
    CLK_FAST = 2'b10,
    CLK_EXT  = 2'b11
  } smt_clk_e;

  typedef enum logic [1:0] {
    START_STOP = 2'b00,
    START_CMD  = 2'b01,
    START_RISE = 2'b10,
    START_FALL = 2'b11
  } smt_start_e;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_COUNT = 2'b01,
    RUN_HOLD  = 2'b10
  } smt_run_e;

  // Bit 6 is the auto-capture, trigger-stop or capture edge mode bit, by mode.
  typedef struct packed {
    logic       flipflop_ctl;
    logic       opt;
    smt_start_e start;
    smt_clk_e   clk_sel;
    smt_mode_e  mode;
  } smt_ctl_s;

endpackage

// ==== rtl/smt_timer.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - Timer mode counts internal clock; on period match interrupt, clear, keep counting.
// - Auto-capture bit set copies the running count into the capture register.
// - Source clock field picks one of three prescaled clocks, or the pin.
// - External trigger mode waits idle for the selected pin edge, then counts.
// - External trigger match interrupts, clears and halts until next trigger edge.
// - With trigger-stop set, the opposite edge clears and stops the counter.
// - Otherwise opposite edges and repeated triggers before a match are ignored.
// - Pin pulses of seven fc or less are rejected; thirteen fc is detected.
// - Event counter mode counts selected pin edges; match interrupts and clears.
// - Event match is checked only on the edge opposite to counting.
// - Window mode counts internal clock ANDed with pin; match interrupts, clears.
// - Start field selects active-high or active-low window input.
// - Pulse mode starts on trigger edge, captures and interrupts on opposite edge.
// - Bit 6 chooses single edge capture (1) or double edge capture (0).
// - Single edge loads one at capture; double keeps counting, captures again at trigger.
// - After a single edge capture the counter sits at one until the next trigger edge.
module smt_timer
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // Register port
  input  wire logic [smt_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [smt_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output      logic [smt_pkg::DATA_W-1:0] reg_rdata,
  // System control
  input  wire logic                       prescaler_select,
  input  wire logic                       stop_req,
  // Pin and event
  input  wire logic                       timer_input_pin,
  output      logic                       match_interrupt
);
  import smt_pkg::*;

  typedef struct packed {
    smt_ctl_s          ctl;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  stage;
    logic              pend;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  cap;
    smt_run_e          run;
    logic [DIV_W-1:0]  div;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } smt_state_s;

  smt_state_s s;
  smt_state_s next_s;

  smt_pin_if pin_if ();

  logic       tick;
  logic       ext_clk;
  logic       trig_edge;
  logic       opp_edge;
  logic       src_edge;
  logic       match;
  logic       win_open;
  logic       timer_on;
  logic       evt_on;
  logic       trig_on;
  logic       win_on;
  logic       pulse_on;
  logic       acap_on;

  // Exponent of the selected internal source clock; the prescaler input adds one to it.
  function automatic logic [3:0] smt_div_exp(input smt_clk_e sel, input logic slow);
    logic [3:0] base;
    unique case (sel)
      CLK_SLOW: base = DIV_EXP_SLOW;
      CLK_MID:  base = DIV_EXP_MID;
      CLK_FAST: base = DIV_EXP_FAST;
      CLK_EXT:  base = DIV_EXP_FAST;
    endcase
    return base + {3'h0, slow};
  endfunction

  function automatic logic smt_div_tick(input logic [DIV_W-1:0] div, input logic [3:0] exp);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((14'h0001 << exp) - 14'h0001);
    return (div & mask) == mask;
  endfunction

  // Returns the interrupt flag above the next count for a match-and-clear step.
  function automatic logic [CNT_W:0] smt_step(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] period);
    return (cnt == period) ? {1'b1, CNT_CLEAR} : {1'b0, cnt + CNT_ONE};
  endfunction

  smt_pin_filter u_filter (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .timer_input_pin (timer_input_pin),
    .filt            (pin_if)
  );

  assign ext_clk   = s.ctl.clk_sel == CLK_EXT;
  assign tick      = smt_div_tick(s.div, smt_div_exp(s.ctl.clk_sel, prescaler_select));
  assign trig_edge = (s.ctl.start == START_FALL) ? pin_if.fall : pin_if.rise;
  assign opp_edge  = (s.ctl.start == START_FALL) ? pin_if.rise : pin_if.fall;
  assign src_edge  = ext_clk ? trig_edge : tick;
  assign match     = s.cnt == s.period;
  assign win_open  = pin_if.level ^ (s.ctl.start == START_FALL);

  assign timer_on  = s.ctl.mode == MODE_TIMER && !ext_clk && s.ctl.start == START_CMD;
  assign evt_on    = s.ctl.mode == MODE_TIMER && ext_clk && s.ctl.start != START_STOP;
  assign trig_on   = s.ctl.mode == MODE_TIMER && !ext_clk && s.ctl.start[1];
  assign win_on    = s.ctl.mode == MODE_WINDOW && s.ctl.start != START_STOP;
  assign pulse_on  = s.ctl.mode == MODE_PULSE && s.ctl.start != START_STOP;
  assign acap_on   = s.ctl.opt && (s.ctl.mode == MODE_WINDOW || (s.ctl.mode == MODE_TIMER
                     && (ext_clk || s.ctl.start == START_CMD)));

  always_comb
  begin
    next_s       = s;
    next_s.irq   = 1'b0;
    next_s.rdata = RDATA_IDLE;
    next_s.div   = s.div + DIV_ONE;

    // A half-written period never reaches the comparator.
    if (s.pend && src_edge)
    begin
      next_s.period = s.stage;
      next_s.pend   = 1'b0;
    end

    if (s.ctl.start == START_STOP)
    begin
      next_s.cnt = CNT_CLEAR;
      next_s.run = RUN_IDLE;
    end
    else
    begin
      unique case (s.ctl.mode)
        MODE_TIMER:
        begin
          if (ext_clk)
          begin
            if (trig_edge)
            begin
              next_s.cnt = s.cnt + CNT_ONE;
            end
            else if (opp_edge && match)
            begin
              next_s.irq = 1'b1;
              next_s.cnt = CNT_CLEAR;
            end
          end
          else if (s.ctl.start == START_CMD)
          begin
            if (tick)
            begin
              {next_s.irq, next_s.cnt} = smt_step(s.cnt, s.period);
            end
          end
          else
          begin
            unique case (s.run)
              RUN_IDLE:
              begin
                if (trig_edge)
                begin
                  next_s.run = RUN_COUNT;
                end
              end
              RUN_COUNT:
              begin
                // Further trigger edges fall through here unseen until a match.
                if (s.ctl.opt && opp_edge) // and
                begin
                  next_s.cnt = CNT_CLEAR;
                  next_s.run = RUN_IDLE;
                end
                else if (tick)
                begin
                  {next_s.irq, next_s.cnt} = smt_step(s.cnt, s.period);
                  if (match)
                  begin
                    next_s.run = RUN_IDLE;
                  end
                end
              end
              default:
              begin
                next_s.run = RUN_IDLE;
              end
            endcase
          end
        end
        MODE_WINDOW:
        begin
          if (tick && win_open)
          begin
            {next_s.irq, next_s.cnt} = smt_step(s.cnt, s.period);
          end
        end
        MODE_PULSE:
        begin
          unique case (s.run)
            RUN_IDLE:
            begin
              if (trig_edge)
              begin
                next_s.cnt = CNT_CLEAR;
                next_s.run = RUN_COUNT;
              end
            end
            RUN_COUNT:
            begin
              if (opp_edge)
              begin
                next_s.cap = s.cnt;
                next_s.irq = 1'b1;
                if (s.ctl.opt) // and
                begin
                  next_s.cnt = CNT_ONE;
                  next_s.run = RUN_HOLD;
                end
              end
              else if (trig_edge && !s.ctl.opt)
              begin
                next_s.cap = s.cnt;
                next_s.irq = 1'b1;
                next_s.cnt = CNT_ONE;
              end
              else if (tick)
              begin
                next_s.cnt = s.cnt + CNT_ONE;
              end
            end
            RUN_HOLD:
            begin
              if (trig_edge)
              begin
                next_s.run = RUN_COUNT;
              end
            end
            default:
            begin
              next_s.run = RUN_IDLE;
            end
          endcase
        end
        MODE_PPG:
        begin
          next_s.run = RUN_IDLE;
        end
      endcase
    end

    if (acap_on)
    begin
      next_s.cap = s.cnt;
    end

    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_PERIOD_LO: next_s.stage[7:0] = reg_wdata;
        ADDR_PERIOD_HI:
        begin
          next_s.stage[15:8] = reg_wdata;
          next_s.pend        = 1'b1;
        end
        ADDR_CONTROL:
        begin
          next_s.ctl              = smt_ctl_s'(reg_wdata);
          next_s.ctl.flipflop_ctl = 1'b0;
        end
        default: next_s.pend = s.pend;
      endcase
    end

    // Stop entry overrides the start field of a control write in the same cycle.
    if (stop_req)
    begin
      next_s.ctl.start = START_STOP;
    end

    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_PERIOD_LO:  next_s.rdata = s.period[7:0];
        ADDR_PERIOD_HI:  next_s.rdata = s.period[15:8];
        ADDR_CAPTURE_LO: next_s.rdata = s.cap[7:0];
        ADDR_CAPTURE_HI: next_s.rdata = s.cap[15:8];
        ADDR_CONTROL:    next_s.rdata = s.ctl;
        default:         next_s.rdata = RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s        <= '0;
      s.ctl    <= smt_ctl_s'(CTL_RESET);
      s.period <= PERIOD_RESET;
      s.stage  <= PERIOD_RESET;
      s.cap    <= CAPTURE_RESET;
      s.run    <= RUN_IDLE;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  assign reg_rdata       = s.rdata;
  assign match_interrupt = s.irq;

  default clocking smt_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence pw_opp_capture;
    pulse_on && s.run == RUN_COUNT && opp_edge && clk_en;
  endsequence

  sequence pw_caught;
    match_interrupt && s.cap == $past(s.cnt);
  endsequence

  timer_wrap_a: assert property (timer_on && tick && match && clk_en |=> s.cnt == CNT_CLEAR && match_interrupt)
    else $error("Timer match did not clear and interrupt.");

  auto_capture_a: assert property (acap_on && clk_en |=> s.cap == $past(s.cnt))
    else $error("Auto-capture did not follow the count.");

  event_count_a: assert property (evt_on && !trig_edge && !opp_edge && clk_en |=> $stable(s.cnt))
    else $error("Event counter moved without a pin edge.");

  trigger_idle_a: assert property (trig_on && s.run == RUN_IDLE && !trig_edge && clk_en
    |=> s.run == RUN_IDLE && $stable(s.cnt))
    else $error("Trigger timer left idle without an edge.");

  trigger_halt_a: assert property (trig_on && s.run == RUN_COUNT && tick && match && !(s.ctl.opt && opp_edge)
    && clk_en |=> s.run == RUN_IDLE && s.cnt == CNT_CLEAR && match_interrupt)
    else $error("Trigger timer did not halt on match.");

  trigger_stop_a: assert property (trig_on && s.ctl.opt && s.run == RUN_COUNT && opp_edge && clk_en
    |=> s.run == RUN_IDLE && s.cnt == CNT_CLEAR && !match_interrupt)
    else $error("Opposite edge did not stop the trigger timer.");

  trigger_ignore_a: assert property (trig_on && !s.ctl.opt && s.run == RUN_COUNT && !tick && clk_en
    |=> s.run == RUN_COUNT && $stable(s.cnt))
    else $error("Trigger timer reacted to an ignored edge.");

  event_compare_a: assert property (evt_on && !(opp_edge && match) && clk_en |=> !match_interrupt)
    else $error("Event match raised away from the opposite edge.");

  window_gate_a: assert property (win_on && !win_open && clk_en |=> $stable(s.cnt) && !match_interrupt)
    else $error("Window counter moved with the window closed.");

  pulse_capture_a: assert property (pw_opp_capture |=> pw_caught)
    else $error("Pulse edge did not capture and interrupt.");

  pulse_hold_a: assert property (pulse_on && s.run == RUN_HOLD && !trig_edge && clk_en
    |=> s.cnt == CNT_ONE && s.run == RUN_HOLD)
    else $error("Pulse counter did not hold at one.");

  period_load_a: assert property (s.pend && src_edge && clk_en |=> s.period == $past(s.stage))
    else $error("Staged period was not loaded on the source edge.");

  stop_clear_a: assert property (s.ctl.start == START_STOP && clk_en
    |=> s.cnt == CNT_CLEAR && s.run == RUN_IDLE)
    else $error("Stopped counter was not cleared.");

  stop_entry_a: assert property (stop_req && clk_en |=> s.ctl.start == START_STOP)
    else $error("Stop entry did not clear the start field.");

endmodule // smt_timer

// ==== verif/smt_pin_src.sv ====
`timescale 1ns/1ns
// Behavioural source of the timer input pin; levels change just after a clock edge.
module smt_pin_src
(
  // Clock
  input  wire logic core_clk,
  // Pin
  output      logic timer_input_pin
);
  initial timer_input_pin = 1'b0;

  // Legal levels are held thirteen fc or more; shorter holds are only used when a test asks for noise.
  task automatic hold(input logic level, input int cycles);
    @(posedge core_clk);
    timer_input_pin <= level;
    repeat (cycles - 1) @(posedge core_clk);
  endtask

  // Drives the level for width cycles, then the opposite level for gap cycles.
  task automatic pulse(input logic level, input int width, input int gap);
    hold(level, width);
    hold(!level, gap);
  endtask
endmodule // smt_pin_src

// ==== verif/smt_timer_tb_top.sv ====
`timescale 1ns/1ns
module smt_timer_tb_top;
  import smt_pkg::*;

  localparam int TIMEOUT = 60000;

  logic                core_clk;
  logic                rst_n;
  logic                clk_en;
  logic [ADDR_W-1:0]   reg_addr;
  logic [DATA_W-1:0]   reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [DATA_W-1:0]   reg_rdata;
  logic                prescaler_select;
  logic                stop_req;
  logic                timer_input_pin;
  logic                match_interrupt;
  logic [31:0]         rng = 32'h3a5be429;
  int                  fail_count;
  int                  comparisons;
  int                  cyc;
  int                  irq_cnt;
  int                  last_irq;
  int                  irq_gap;

  smt_timer u_smt_timer
  (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .clk_en           (clk_en),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .prescaler_select (prescaler_select),
    .stop_req         (stop_req),
    .timer_input_pin  (timer_input_pin),
    .match_interrupt  (match_interrupt)
  );

  smt_pin_src u_smt_pin_src
  (
    .core_clk        (core_clk),
    .timer_input_pin (timer_input_pin)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Interval between matches of a free-running timer whose source clock divides fc by two to the shift.
  function automatic int exp_gap(input int per, input int shift);
    return (per + 1) << shift;
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (match_interrupt === 1'b1)
    begin
      irq_cnt++;
      irq_gap = cyc - last_irq;
      last_irq = cyc;
    end
    if (cyc > TIMEOUT)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_num(input string name, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic chk_range(input string name, input int lo, input int hi, input logic [15:0] got);
    comparisons++;
    if ($isunknown(got) || int'(got) < lo || int'(got) > hi)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", name, lo, hi, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Read data stand for one cycle only, so they are taken at the edge that closes it.
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi, lo};
  endtask

  // Stop first so mode changes happen while halted, load the period, then start.
  task automatic setup(input logic [7:0] ctl, input logic [15:0] per);
    wr(ADDR_CONTROL, 8'h08);
    wr(ADDR_PERIOD_LO, per[7:0]);
    wr(ADDR_PERIOD_HI, per[15:8]);
    idle(40);
    wr(ADDR_CONTROL, ctl & 8'hcf);
    wr(ADDR_CONTROL, ctl);
    irq_cnt = 0;
  endtask

  initial
  begin : main
    logic [7:0]  d;
    logic [15:0] v;
    int          per;
    int          w;
    int          g;
    int          t0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    prescaler_select = 1'b0;
    stop_req = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 16; a < 22; a++)
    begin
      rd(8'(a), d);
      chk_reg("reset_value", 8'h00, d);
    end
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, d);
    chk_reg("control_bit7", 8'h7f, d);
    wr(ADDR_CAPTURE_LO, 8'h5a);
    rd(ADDR_CAPTURE_LO, d);
    chk_reg("capture_read_only", 8'h00, d);
    wr(8'h15, 8'ha5);
    rd(8'h15, d);
    chk_reg("unmapped", 8'h00, d);
    $display("test registers done");
    for (int ps = 0; ps < 2; ps++)
      for (int k = 0; k < 3; k++)
      begin
        per = 2 + int'(xs() % 4);
        @(posedge core_clk);
        prescaler_select <= ps[0];
        setup(8'h18, 16'(per));
        rd16(ADDR_PERIOD_LO, v);
        chk_range("period", per, per, v);
        for (int i = 0; i < 600 && irq_cnt < 3; i++) @(posedge core_clk);
        chk_num("timer_gap", exp_gap(per, 3 + ps), irq_gap);
        wr(ADDR_PERIOD_LO, 8'hff);
        idle(40);
        rd16(ADDR_PERIOD_LO, v);
        chk_range("period_low_only", per, per, v);
        wr(ADDR_CONTROL, 8'h58);
        idle(3);
        rd16(ADDR_CAPTURE_LO, v);
        chk_range("auto_capture", 0, per, v);
      end
    prescaler_select <= 1'b0;
    // The middle and slow source clocks, with a period of one to keep the run short.
    for (int c = 0; c < 2; c++)
    begin
      setup(c ? 8'h10 : 8'h14, 16'h0001);
      for (int i = 0; i < 9000 && irq_cnt < 2; i++) @(posedge core_clk);
      chk_num("source_clock_gap", exp_gap(1, c ? 11 : 7), irq_gap);
    end
    $display("test timer done");
    wr(ADDR_CONTROL, 8'h18);
    @(posedge core_clk);
    stop_req <= 1'b1;
    @(posedge core_clk);
    stop_req <= 1'b0;
    rd(ADDR_CONTROL, d);
    chk_reg("stop_entry", 8'h08, d);
    // A write while the clock enable is low must leave every register as it was.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(ADDR_CONTROL, 8'h5a);
    clk_en <= 1'b1;
    rd(ADDR_CONTROL, d);
    chk_reg("frozen_write", 8'h08, d);
    irq_cnt = 0;
    idle(200);
    chk_num("stopped_irqs", 0, irq_cnt);
    $display("test stop done");
    setup(8'h28, 16'h0002);
    u_smt_pin_src.pulse(1'b1, 7, 100);
    chk_num("noise_pulse", 0, irq_cnt);
    u_smt_pin_src.pulse(1'b1, 20, 200);
    chk_num("trigger_start", 1, irq_cnt);
    idle(300);
    chk_num("halt_after_match", 1, irq_cnt);
    u_smt_pin_src.pulse(1'b1, 20, 200);
    chk_num("retrigger", 2, irq_cnt);
    setup(8'h68, 16'h0100);
    u_smt_pin_src.pulse(1'b1, 20, 2500);
    chk_num("trigger_stop", 0, irq_cnt);
    setup(8'h28, 16'h0100);
    u_smt_pin_src.pulse(1'b1, 20, 2500);
    chk_num("opposite_ignored", 1, irq_cnt);
    $display("test trigger done");
    setup(8'h1c, 16'h0003);
    repeat (8) u_smt_pin_src.pulse(1'b1, 16, 16);
    idle(40);
    chk_num("event_matches", 2, irq_cnt);
    $display("test event done");
    for (int pol = 0; pol < 2; pol++)
    begin
      setup(pol ? 8'h39 : 8'h19, 16'h0003);
      u_smt_pin_src.hold(pol[0], 300);
      chk_num("window_closed", 0, irq_cnt);
      u_smt_pin_src.hold(!pol[0], 300);
      chk_range("window_open", 1, 100, 16'(irq_cnt));
    end
    u_smt_pin_src.hold(1'b0, 40);
    $display("test window done");
    for (int single = 0; single < 2; single++)
    begin
      setup(single ? 8'h6a : 8'h2a, 16'hffff);
      w = 80 + int'(xs() % 120);
      g = 80 + int'(xs() % 120);
      t0 = cyc;
      u_smt_pin_src.pulse(1'b1, w, 40);
      rd16(ADDR_CAPTURE_LO, v);
      chk_range("first_capture", w / 8 - 2, w / 8 + 2, v);
      chk_num("first_capture_irq", 1, irq_cnt);
      u_smt_pin_src.hold(1'b0, g);
      u_smt_pin_src.hold(1'b1, 40);
      rd16(ADDR_CAPTURE_LO, v);
      if (single)
        chk_range("single_hold", w / 8 - 2, w / 8 + 2, v);
      else
        chk_range("double_capture", (cyc - 40 - t0) / 8 - 2, (cyc - 40 - t0) / 8 + 2, v);
      chk_num("capture_irqs", 2 - single, irq_cnt);
      u_smt_pin_src.hold(1'b0, 40);
    end
    $display("test pulse done");
    end_sim();
  end
endmodule // smt_timer_tb_top
